// ==== design/sbus_pkg.sv ====
// constants shared by the addressed serial bus mode logic
package sbus_pkg;
	// ------------------------------------------------------------
	// register addresses
	// ------------------------------------------------------------
	localparam logic [15:0] ADDR_MODE     = 16'hFF60;
	localparam logic [15:0] ADDR_CONTROL  = 16'hFF61;
	localparam logic [15:0] ADDR_SHIFT    = 16'hFF62;
	localparam logic [15:0] ADDR_SLAVE    = 16'hFF63;
	// ------------------------------------------------------------
	// reset values
	// ------------------------------------------------------------
	localparam logic [7:0]  MODE_RESET    = 8'h01;
	localparam logic [7:0]  CONTROL_RESET = 8'h00;
	localparam logic [7:0]  BYTE_ZERO     = 8'h00;
	// ------------------------------------------------------------
	// mode register fields
	// ------------------------------------------------------------
	localparam int MODE_ENABLE   = 7;
	localparam int MODE_COMPARE  = 6;
	localparam int MODE_WAKE     = 5;
	localparam int MODE_FIELD_HI = 4;
	localparam int MODE_FIELD_LO = 2;
	localparam int MODE_CLKSEL   = 1;
	localparam int MODE_FIXED    = 0;
	localparam logic [2:0] MODE_BUS_LINE_A = 3'h5;
	localparam logic [2:0] MODE_BUS_LINE_B = 3'h4;
	// ------------------------------------------------------------
	// control register fields
	// ------------------------------------------------------------
	localparam int CTL_BUSY_EN  = 7;
	localparam int CTL_ACK_DET  = 6;
	localparam int CTL_AUTO_ACK = 5;
	localparam int CTL_ACK_TRIG = 4;
	localparam int CTL_CMD_DET  = 3;
	localparam int CTL_REL_DET  = 2;
	localparam int CTL_CMD_TRIG = 1;
	localparam int CTL_REL_TRIG = 0;
	// ------------------------------------------------------------
	// transfer framing
	// ------------------------------------------------------------
	localparam logic [3:0] BITS_PER_BYTE = 4'h8;
	localparam logic [3:0] CLOCKS_PER_XFER = 4'h9;
	localparam logic [19:0] HALF_BASE = 20'h00002;
endpackage

// ==== design/sbus_sync.sv ====
// two-flop synchroniser with edge strobes for a group of pins
`timescale 1ns/1ps
`default_nettype none
module sbus_sync #(
	parameter int WIDTH = 3
) (
	// clock and reset
	input  wire logic             core_clk,
	input  wire logic             rst,
	// pins in, levels and strobes out
	input  wire logic [WIDTH-1:0] pin,
	output logic      [WIDTH-1:0] level,
	output logic      [WIDTH-1:0] rise,
	output logic      [WIDTH-1:0] fall
);
	logic [WIDTH-1:0] stage1;
	logic [WIDTH-1:0] prev;

	initial
	begin
		if (WIDTH < 1) $error("sbus_sync needs at least one pin");
	end

	// first stage feeds only the second; pins idle high on the pulled-up bus
	always_ff @(posedge core_clk or posedge rst)
	begin
		if (rst)
		begin
			stage1 <= '1;
			level  <= '1;
			prev   <= '1;
		end
		else
		begin
			stage1 <= pin;
			level  <= stage1;
			prev   <= level;
		end
	end

	// edges compare the settled stage with its previous value
	assign rise = level & ~prev;
	assign fall = ~level & prev;
endmodule // sbus_sync
`default_nettype wire

// ==== design/sbus_mode.sv ====
// addressed two-wire serial bus mode logic with its mode, control, shift and slave address registers
// How it works
// [RQ1] mode register resets 01H, bit0 reads 1
// [RQ2] field 101 uses line a, 100 line b
// [RQ3] clock select picks pin or internal divider
// [RQ4] wake-up off: interrupt after every transfer
// [RQ5] wake-up on: interrupt only on address match
// [RQ6] compare flag shows match, zero when disabled
// [RQ7] software clears cause select for wake-up
// [RQ8] trigger bits always read back zero
// [RQ9] release trigger sets latch, self clears
// [RQ10] command trigger clears latch, self clears
// [RQ11] release flag set on edge, cleared variously
// [RQ12] command flag set on edge, cleared variously
// [RQ13] ack trigger gives one ack next fall
// [RQ14] auto ack drives ack on ninth fall
// [RQ15] late auto ack acks next fall, stays set
// [RQ16] ack flag on low at rise after transfer
// [RQ17] busy enable holds line low after ack
// [RQ18] transfer start ends busy, keeps enable
// [RQ19] receiver holds line low one clock ack
// [RQ20] release and command edges while clock high
// [RQ21] eight data clocks, interrupt at ninth rise
// [RQ22] shift write while enabled starts transfer
// [RQ23] byte after release and command is address
// [RQ24] msb out on falls, sample on rises
`timescale 1ns/1ps
`default_nettype none
module sbus_mode (
	// clock and reset
	input  wire logic        core_clk,
	input  wire logic        rst,
	// cpu register access
	input  wire logic [15:0] reg_addr,
	input  wire logic        reg_wr,
	input  wire logic        reg_rd,
	input  wire logic [7:0]  reg_wdata,
	output logic      [7:0]  reg_rdata,
	// internal clock choice from the timer clock select register
	input  wire logic [3:0]  timer_clock_select,
	// serial clock pin
	input  wire logic        serial_clock_in,
	output logic             serial_clock_out,
	output logic             serial_clock_oe,
	// open-drain data lines
	input  wire logic        data_line_a_in,
	output logic             data_line_a_out,
	output logic             data_line_a_oe,
	input  wire logic        data_line_b_in,
	output logic             data_line_b_out,
	output logic             data_line_b_oe,
	// transfer interrupt request
	output logic             transfer_irq
);
	import sbus_pkg::*;

	// ------------------------------------------------------------
	// state
	// ------------------------------------------------------------
	logic        channel_enable;
	logic        wake_up_enable;
	logic [2:0]  mode_field;
	logic        clock_source_select;
	logic        address_compare_flag;
	logic        busy_enable;
	logic        auto_ack_enable;
	logic        ack_trigger;
	logic        release_trigger;
	logic        command_trigger;
	logic        ack_detect_flag;
	logic        command_detect_flag;
	logic        release_detect_flag;
	logic [7:0]  slave_address_reg;
	logic [7:0]  serial_shift_reg;
	logic        so_latch;
	logic [3:0]  bit_cnt;
	logic        active;
	logic        pending;
	logic        xfer_done;
	logic        ack_drive;
	logic        ack_done;
	logic        busy_drive;
	logic        ack_detect_flag_clear_pending;
	logic        gen_sck;
	logic        gen_rise;
	logic        gen_fall;
	logic [19:0] div_cnt;
	logic [3:0]  gen_rises;
	logic [2:0]  pin_level;
	logic [2:0]  pin_rise;
	logic [2:0]  pin_fall;

	// ------------------------------------------------------------
	// decode and pin selection
	// ------------------------------------------------------------
	function automatic logic hit(input logic [15:0] a, input logic [15:0] target);
		hit = (a == target);
	endfunction

	logic wr_mode;
	logic wr_ctl;
	logic wr_shift;
	logic wr_slave;
	logic bus_mode;
	logic use_line_b;
	logic internal;
	logic sck_level;
	logic sck_rise;
	logic sck_fall;
	logic sda_level;
	logic sda_rise;
	logic sda_fall;
	logic rel_edge;
	logic cmd_edge;
	logic start_now;
	logic ninth_rise;
	logic addr_byte;
	logic drive_low;
	logic [19:0] half_period;

	assign wr_mode    = reg_wr && hit(reg_addr, ADDR_MODE);
	assign wr_ctl     = reg_wr && hit(reg_addr, ADDR_CONTROL);
	assign wr_shift   = reg_wr && hit(reg_addr, ADDR_SHIFT);
	assign wr_slave   = reg_wr && hit(reg_addr, ADDR_SLAVE);
	// line a for 101, line b for 100
	assign use_line_b = (mode_field == MODE_BUS_LINE_B); // RQ2
	assign bus_mode   = channel_enable && (use_line_b || mode_field == MODE_BUS_LINE_A); // RQ2
	// pin clock or the divider, chosen by the clock source bit
	assign internal   = clock_source_select; // RQ3
	assign sck_level  = internal ? gen_sck  : pin_level[0];
	assign sck_rise   = internal ? gen_rise : pin_rise[0];
	assign sck_fall   = internal ? gen_fall : pin_fall[0];
	assign sda_level  = use_line_b ? pin_level[2] : pin_level[1];
	assign sda_rise   = use_line_b ? pin_rise[2]  : pin_rise[1];
	assign sda_fall   = use_line_b ? pin_fall[2]  : pin_fall[1];
	// data edges only count as bus signals while the clock rests high
	assign rel_edge   = bus_mode && sck_level && sda_rise; // RQ20
	assign cmd_edge   = bus_mode && sck_level && sda_fall; // RQ20
	assign ninth_rise = active && sck_rise && bit_cnt == BITS_PER_BYTE; // RQ21
	assign addr_byte  = release_detect_flag && command_detect_flag; // RQ23
	// a master waits for the slave to show ready before clocking
	assign start_now  = pending && bus_mode && !active && (!internal || sda_level);
	assign half_period = HALF_BASE << timer_clock_select; // RQ3

	sbus_sync #(
		.WIDTH(3)
	) u_sync (
		.core_clk(core_clk),
		.rst     (rst),
		.pin     ({data_line_b_in, data_line_a_in, serial_clock_in}),
		.level   (pin_level),
		.rise    (pin_rise),
		.fall    (pin_fall)
	);

	// ------------------------------------------------------------
	// mode register and slave address
	// ------------------------------------------------------------
	// writes to the fixed bit and the compare flag are ignored
	always_ff @(posedge core_clk or posedge rst)
	begin
		if (rst)
		begin
			channel_enable      <= MODE_RESET[MODE_ENABLE]; // RQ1
			wake_up_enable      <= MODE_RESET[MODE_WAKE];
			mode_field          <= MODE_RESET[MODE_FIELD_HI:MODE_FIELD_LO];
			clock_source_select <= MODE_RESET[MODE_CLKSEL];
			slave_address_reg   <= BYTE_ZERO;
		end
		else
		begin
			if (wr_mode)
			begin
				channel_enable      <= reg_wdata[MODE_ENABLE];
				wake_up_enable      <= reg_wdata[MODE_WAKE];
				mode_field          <= reg_wdata[MODE_FIELD_HI:MODE_FIELD_LO];
				clock_source_select <= reg_wdata[MODE_CLKSEL];
			end
			if (wr_slave)
				slave_address_reg <= reg_wdata;
		end
	end

	// compare flag is held at zero while the channel is stopped
	always_ff @(posedge core_clk or posedge rst)
	begin
		if (rst)
			address_compare_flag <= 1'b0;
		else
			address_compare_flag <= channel_enable && (slave_address_reg == serial_shift_reg); // RQ6
	end

	// ------------------------------------------------------------
	// control register: enables, triggers, detect flags
	// ------------------------------------------------------------
	always_ff @(posedge core_clk or posedge rst)
	begin
		if (rst)
		begin
			busy_enable     <= CONTROL_RESET[CTL_BUSY_EN];
			auto_ack_enable <= CONTROL_RESET[CTL_AUTO_ACK];
			release_trigger <= CONTROL_RESET[CTL_REL_TRIG];
			command_trigger <= CONTROL_RESET[CTL_CMD_TRIG];
		end
		else
		begin
			if (wr_ctl)
			begin
				busy_enable     <= reg_wdata[CTL_BUSY_EN];
				auto_ack_enable <= reg_wdata[CTL_AUTO_ACK]; // RQ15
			end
			// latch follows one cycle later, as the trigger drops
			release_trigger <= wr_ctl && reg_wdata[CTL_REL_TRIG] && channel_enable; // RQ9
			command_trigger <= wr_ctl && reg_wdata[CTL_CMD_TRIG] && channel_enable; // RQ10
		end
	end

	// ack trigger waits for the next falling clock edge
	always_ff @(posedge core_clk or posedge rst)
	begin
		if (rst)
			ack_trigger <= CONTROL_RESET[CTL_ACK_TRIG];
		else if (!channel_enable || wr_shift)
			ack_trigger <= 1'b0; // RQ13
		else if (wr_ctl && reg_wdata[CTL_ACK_TRIG])
			ack_trigger <= 1'b1;
		else if (sck_fall && !active && xfer_done && !auto_ack_enable)
			ack_trigger <= 1'b0; // RQ13
	end

	// detect flags: an edge in the cycle of a clearing event wins
	always_ff @(posedge core_clk or posedge rst)
	begin
		if (rst)
		begin
			release_detect_flag <= CONTROL_RESET[CTL_REL_DET];
			command_detect_flag <= CONTROL_RESET[CTL_CMD_DET];
		end
		else if (!channel_enable)
		begin
			release_detect_flag <= 1'b0; // RQ11
			command_detect_flag <= 1'b0; // RQ12
		end
		else
		begin
			if (rel_edge)
				release_detect_flag <= 1'b1; // RQ11
			else if (wr_shift || (ninth_rise && addr_byte && serial_shift_reg != slave_address_reg))
				release_detect_flag <= 1'b0; // RQ11
			if (cmd_edge)
				command_detect_flag <= 1'b1; // RQ12
			else if (wr_shift || rel_edge)
				command_detect_flag <= 1'b0; // RQ12
		end
	end

	// ack seen low on a rise after the byte; cleared at the fall after start
	always_ff @(posedge core_clk or posedge rst)
	begin
		if (rst)
		begin
			ack_detect_flag    <= CONTROL_RESET[CTL_ACK_DET];
			ack_detect_flag_clear_pending <= 1'b0;
		end
		else if (!channel_enable)
		begin
			ack_detect_flag    <= 1'b0; // RQ16
			ack_detect_flag_clear_pending <= 1'b0;
		end
		else
		begin
			if (sck_rise && !sda_level && (ninth_rise || xfer_done))
				ack_detect_flag <= 1'b1; // RQ16
			else if (sck_fall && ack_detect_flag_clear_pending)
				ack_detect_flag <= 1'b0; // RQ16
			if (wr_shift)
				ack_detect_flag_clear_pending <= 1'b1;
			else if (sck_fall)
				ack_detect_flag_clear_pending <= 1'b0;
		end
	end

	// ------------------------------------------------------------
	// shift engine
	// ------------------------------------------------------------
	// with the internal clock, a write is kept pending until the line shows ready
	always_ff @(posedge core_clk or posedge rst)
	begin
		if (rst)
		begin
			serial_shift_reg <= BYTE_ZERO;
			so_latch         <= 1'b1;
			bit_cnt          <= 4'h0;
			active           <= 1'b0;
			pending          <= 1'b0;
			xfer_done        <= 1'b0;
		end
		else
		begin
			if (release_trigger)
				so_latch <= 1'b1; // RQ9
			else if (command_trigger)
				so_latch <= 1'b0; // RQ10
			else if (active && sck_fall && bit_cnt < BITS_PER_BYTE)
				so_latch <= serial_shift_reg[7]; // RQ24
			if (wr_shift && channel_enable)
			begin
				serial_shift_reg <= reg_wdata; // RQ22
				// a write during a running byte only reloads data, no second start
				pending          <= !active; // RQ22
				xfer_done        <= 1'b0;
			end
			else if (!channel_enable)
			begin
				pending <= 1'b0;
				active  <= 1'b0;
			end
			else if (start_now)
			begin
				pending <= 1'b0;
				active  <= 1'b1;
				bit_cnt <= 4'h0;
			end
			else if (active && sck_rise)
			begin
				if (bit_cnt < BITS_PER_BYTE)
				begin
					serial_shift_reg <= {serial_shift_reg[6:0], sda_level}; // RQ24
					bit_cnt          <= bit_cnt + 4'h1;
				end
				else
				begin
					active    <= 1'b0; // RQ21
					xfer_done <= 1'b1;
				end
			end
		end
	end

	// ------------------------------------------------------------
	// acknowledge and busy drive
	// ------------------------------------------------------------
	always_ff @(posedge core_clk or posedge rst)
	begin
		if (rst)
		begin
			ack_drive  <= 1'b0;
			ack_done   <= 1'b0;
			busy_drive <= 1'b0;
		end
		else if (!channel_enable || wr_shift)
		begin
			ack_drive  <= 1'b0;
			ack_done   <= 1'b0;
			busy_drive <= 1'b0; // RQ18
		end
		else if (sck_fall)
		begin
			if (active && bit_cnt == BITS_PER_BYTE && auto_ack_enable)
			begin
				ack_drive <= 1'b1; // RQ14
				ack_done  <= 1'b1;
			end
			else if (!active && xfer_done && !ack_done && (auto_ack_enable || ack_trigger))
			begin
				ack_drive <= 1'b1; // RQ15
				ack_done  <= 1'b1;
			end
			else if (ack_drive)
			begin
				ack_drive  <= 1'b0; // RQ19
				busy_drive <= busy_enable; // RQ17
			end
			else if (!busy_enable)
				busy_drive <= 1'b0; // RQ17
		end
	end

	// ------------------------------------------------------------
	// internal clock: nine pulses per byte, resting high
	// ------------------------------------------------------------
	always_ff @(posedge core_clk or posedge rst)
	begin
		if (rst)
		begin
			gen_sck   <= 1'b1;
			gen_rise  <= 1'b0;
			gen_fall  <= 1'b0;
			div_cnt   <= 20'h00000;
			gen_rises <= 4'h0;
		end
		else
		begin
			gen_rise <= 1'b0;
			gen_fall <= 1'b0;
			if (!internal || !bus_mode || start_now)
			begin
				gen_sck   <= 1'b1;
				div_cnt   <= 20'h00000;
				gen_rises <= 4'h0;
			end
			else if (active && gen_rises < CLOCKS_PER_XFER)
			begin
				if (div_cnt >= half_period - 20'h00001)
				begin
					div_cnt  <= 20'h00000;
					gen_sck  <= !gen_sck;
					gen_rise <= !gen_sck;
					gen_fall <= gen_sck;
					if (!gen_sck)
						gen_rises <= gen_rises + 4'h1;
				end
				else
					div_cnt <= div_cnt + 20'h00001;
			end
		end
	end

	// ------------------------------------------------------------
	// pins, interrupt and read data
	// ------------------------------------------------------------
	// wake-up keeps data output released, only ack and busy pull low
	assign drive_low = bus_mode && (ack_drive || busy_drive || (!wake_up_enable && !so_latch));

	always_ff @(posedge core_clk or posedge rst)
	begin
		if (rst)
		begin
			serial_clock_out <= 1'b1;
			serial_clock_oe  <= 1'b0;
			data_line_a_out  <= 1'b0;
			data_line_a_oe   <= 1'b0;
			data_line_b_out  <= 1'b0;
			data_line_b_oe   <= 1'b0;
			transfer_irq     <= 1'b0;
		end
		else
		begin
			serial_clock_out <= gen_sck;
			serial_clock_oe  <= bus_mode && internal; // RQ3
			data_line_a_oe   <= drive_low && !use_line_b; // RQ2
			data_line_b_oe   <= drive_low && use_line_b; // RQ2
			// wake-up gates the request to a matching address byte
			transfer_irq     <= ninth_rise && (!wake_up_enable
				|| (addr_byte && serial_shift_reg == slave_address_reg)); // RQ4 RQ5 RQ21
		end
	end

	// triggers read back as zero and the fixed mode bit as one
	always_ff @(posedge core_clk or posedge rst)
	begin
		if (rst)
			reg_rdata <= BYTE_ZERO;
		else if (!reg_rd)
			reg_rdata <= BYTE_ZERO;
		else if (hit(reg_addr, ADDR_MODE))
			reg_rdata <= {channel_enable, address_compare_flag, wake_up_enable,
				mode_field, clock_source_select, 1'b1}; // RQ1
		else if (hit(reg_addr, ADDR_CONTROL))
			reg_rdata <= {busy_enable, ack_detect_flag, auto_ack_enable, 1'b0,
				command_detect_flag, release_detect_flag, 2'b00}; // RQ8
		else if (hit(reg_addr, ADDR_SHIFT))
			reg_rdata <= serial_shift_reg;
		else if (hit(reg_addr, ADDR_SLAVE))
			reg_rdata <= slave_address_reg;
		else
			reg_rdata <= BYTE_ZERO;
	end

	// ------------------------------------------------------------
	// checks
	// ------------------------------------------------------------
	a_mode_fixed_bit: assert property (@(posedge core_clk) disable iff (rst) // RQ1
		reg_rd && hit(reg_addr, ADDR_MODE) |=> reg_rdata[MODE_FIXED]) else $error("mode bit0 low");
	a_trig_read_zero: assert property (@(posedge core_clk) disable iff (rst) // RQ8
		reg_rd && hit(reg_addr, ADDR_CONTROL) |=> !reg_rdata[CTL_REL_TRIG]
		&& !reg_rdata[CTL_CMD_TRIG] && !reg_rdata[CTL_ACK_TRIG]) else $error("trigger read 1");
	a_compare_off: assert property (@(posedge core_clk) disable iff (rst) // RQ6
		!channel_enable |=> !address_compare_flag) else $error("compare set while off");
	a_release_latch: assert property (@(posedge core_clk) disable iff (rst) // RQ9
		release_trigger |=> so_latch && !release_trigger) else $error("release latch wrong");
	a_command_latch: assert property (@(posedge core_clk) disable iff (rst) // RQ10
		command_trigger && !release_trigger |=> !so_latch) else $error("command latch wrong");
	a_cmd_cleared_rel: assert property (@(posedge core_clk) disable iff (rst) // RQ12
		rel_edge && channel_enable |=> release_detect_flag && !command_detect_flag)
		else $error("release edge flags wrong");
	a_irq_no_wake: assert property (@(posedge core_clk) disable iff (rst) // RQ4
		ninth_rise && !wake_up_enable |=> transfer_irq) else $error("irq missing");
	a_irq_wake_gate: assert property (@(posedge core_clk) disable iff (rst) // RQ5
		transfer_irq && $past(wake_up_enable) |-> $past(addr_byte)) else $error("irq without match");
	a_busy_on_start: assert property (@(posedge core_clk) disable iff (rst) // RQ18
		wr_shift |=> !busy_drive && busy_enable == $past(busy_enable)) else $error("busy kept");
	a_ack_one_fall: assert property (@(posedge core_clk) disable iff (rst) // RQ19
		$rose(ack_drive) |-> !sck_fall [*2]) else $error("ack ended early");
endmodule // sbus_mode
`default_nettype wire

// ==== testbench/sbus_master.sv ====
// bus master model: clocks bytes and sends release and command edges
`timescale 1ns/1ps
`default_nettype none
module sbus_master (
	// clock
	input  wire logic core_clk,
	// data line level seen on the bus
	input  wire logic line,
	// serial clock and open-drain pull
	output logic      scl,
	output logic      pull
);
	initial
	begin
		scl = 1'b1;
		pull = 1'b0;
	end
	// one quarter of the 48 ns link clock
	task automatic wq;
		repeat (3) @(posedge core_clk);
	endtask
	// low then high with clock high
	task automatic bus_release_edge;
		pull <= 1'b1;
		wq();
		pull <= 1'b0;
		wq();
	endtask
	// high then low with clock high
	task automatic cmd;
		wq();
		pull <= 1'b1;
		wq();
	endtask
	// data changes only while the clock is low, msb first
	task automatic send(input logic [7:0] b, output logic ack);
		for (int i = 7; i >= 0; i--)
		begin
			scl <= 1'b0;
			wq();
			pull <= ~b[i];
			wq();
			scl <= 1'b1;
			wq();
			wq();
		end
		scl <= 1'b0;
		wq();
		pull <= 1'b0;
		wq();
		scl <= 1'b1;
		wq();
		ack = ~line;
		wq();
	endtask
	// extra clock after the ack, where busy shows
	task automatic clk10;
		scl <= 1'b0;
		wq();
		wq();
		scl <= 1'b1;
		wq();
		wq();
	endtask
endmodule // sbus_master
`default_nettype wire

// ==== testbench/testbench.sv ====
// self-checking bench for the addressed serial bus mode logic
`timescale 1ns/1ps
`default_nettype none
module testbench;
	import sbus_pkg::*;
	// ------------------------------------------------------------
	// signals
	// ------------------------------------------------------------
	logic        core_clk = 1'b0;
	logic        rst = 1'b1;
	logic [15:0] reg_addr = 16'h0000;
	logic        reg_wr = 1'b0;
	logic        reg_rd = 1'b0;
	logic [7:0]  reg_wdata = 8'h00;
	logic [7:0]  reg_rdata, rv;
	logic        scl_out, scl_oe, a_out, a_oe, b_out, b_oe, transfer_irq;
	logic        m_scl, m_pull, line_a, line_b, scl_line, ack;
	int          num_errors = 0;
	int          samples_checked = 0;
	int          irqs = 0;
	always #2 core_clk = ~core_clk;
	// pull-ups on both data lines; the master pulls only line a
	assign line_a = ~(a_oe | m_pull);
	assign line_b = ~b_oe;
	assign scl_line = scl_oe ? scl_out : m_scl;
	always @(posedge core_clk)
		if (transfer_irq === 1'b1)
			irqs <= irqs + 1;
	sbus_mode u_sbus_mode (
		.core_clk(core_clk), .rst(rst), .reg_addr(reg_addr), .reg_wr(reg_wr),
		.reg_rd(reg_rd), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
		.timer_clock_select(4'h0), .serial_clock_in(scl_line),
		.serial_clock_out(scl_out), .serial_clock_oe(scl_oe),
		.data_line_a_in(line_a), .data_line_a_out(a_out), .data_line_a_oe(a_oe),
		.data_line_b_in(line_b), .data_line_b_out(b_out), .data_line_b_oe(b_oe),
		.transfer_irq(transfer_irq)
	);
	sbus_master u_sbus_master (
		.core_clk(core_clk), .line(line_a), .scl(m_scl), .pull(m_pull)
	);
	// ------------------------------------------------------------
	// shared tasks
	// ------------------------------------------------------------
	task automatic give_verdict;
		if (num_errors == 0 && samples_checked > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask
	task automatic chk(input logic [7:0] g, input logic [7:0] e, input string m);
		samples_checked++;
		if (g !== e)
		begin
			num_errors++;
			$display("wrong value at %0t: %s got %h expected %h", $time, m, g, e);
		end
	endtask
	// write takes effect next cycle; #1 keeps later samples off the edge
	task automatic wr(input logic [15:0] a, input logic [7:0] d);
		@(posedge core_clk);
		reg_addr <= a;
		reg_wdata <= d;
		reg_wr <= 1'b1;
		@(posedge core_clk);
		reg_wr <= 1'b0;
		repeat (2) @(posedge core_clk);
		#1;
	endtask
	task automatic rd(input logic [15:0] a, output logic [7:0] d);
		@(posedge core_clk);
		reg_addr <= a;
		reg_rd <= 1'b1;
		@(posedge core_clk);
		reg_rd <= 1'b0;
		#1;
		d = reg_rdata;
	endtask
	// ------------------------------------------------------------
	// scenarios
	// ------------------------------------------------------------
	task automatic t_regs;
		rd(ADDR_MODE, rv);
		chk(rv, 8'h01, "mode reset");
		rd(ADDR_CONTROL, rv);
		chk(rv, 8'h00, "control reset");
		rd(16'hFF70, rv);
		chk(rv, 8'h00, "unmapped read");
		wr(ADDR_MODE, 8'h90);
		wr(ADDR_CONTROL, 8'h02);
		chk({7'h0, b_oe}, 8'h01, "line b low");
		wr(ADDR_MODE, 8'h96);
		chk({6'h0, scl_oe, scl_out}, 8'h03, "internal clock drives pin");
		wr(ADDR_MODE, 8'h94);
		rd(ADDR_MODE, rv);
		chk(rv & 8'hBF, 8'h95, "mode readback");
		chk({5'h0, scl_oe, a_out, b_out}, 8'h00, "clock input, outs low");
		wr(ADDR_CONTROL, 8'h12);
		chk({6'h0, b_oe, a_oe}, 8'h01, "command latch on line a");
		// the block sees its own command edge, so only that flag stands
		rd(ADDR_CONTROL, rv);
		chk(rv, 8'h08, "triggers read zero");
		wr(ADDR_CONTROL, 8'h01);
		chk({7'h0, a_oe}, 8'h00, "release latch");
	endtask
	task automatic t_addr;
		int n;
		wr(ADDR_SLAVE, 8'hA5);
		wr(ADDR_CONTROL, 8'hA1);
		wr(ADDR_SHIFT, 8'hFF);
		u_sbus_master.bus_release_edge();
		rd(ADDR_CONTROL, rv);
		chk(rv, 8'hA4, "release flag");
		u_sbus_master.cmd();
		rd(ADDR_CONTROL, rv);
		chk(rv, 8'hAC, "command flag");
		n = irqs;
		u_sbus_master.send(8'hA5, ack);
		repeat (12) @(posedge core_clk);
		chk({7'h0, ack}, 8'h01, "auto ack");
		chk(8'(irqs - n), 8'h01, "one interrupt");
		rd(ADDR_CONTROL, rv);
		chk(rv, 8'hEC, "ack flag");
		rd(ADDR_MODE, rv);
		chk(rv & 8'h40, 8'h40, "compare match");
		u_sbus_master.clk10();
		#1;
		chk({7'h0, line_a}, 8'h00, "busy low");
		wr(ADDR_SHIFT, 8'hFF);
		chk({7'h0, line_a}, 8'h01, "ready after start");
		rd(ADDR_CONTROL, rv);
		chk(rv & 8'h8C, 8'h80, "busy enable kept");
		wr(ADDR_CONTROL, 8'h20);
	endtask
	task automatic t_wake;
		int n;
		// cause select lives outside this block and is left clear for wake-up
		wr(ADDR_MODE, 8'hB4);
		wr(ADDR_SLAVE, 8'h5A);
		wr(ADDR_CONTROL, 8'h00);
		n = irqs;
		wr(ADDR_SHIFT, 8'hFF);
		u_sbus_master.bus_release_edge();
		u_sbus_master.cmd();
		u_sbus_master.send(8'h33, ack);
		repeat (12) @(posedge core_clk);
		rd(ADDR_CONTROL, rv);
		chk(rv & 8'h04, 8'h00, "mismatch clears release");
		chk({7'h0, ack}, 8'h00, "no ack with auto off");
		wr(ADDR_CONTROL, 8'h10);
		u_sbus_master.clk10();
		#1;
		chk({7'h0, line_a}, 8'h00, "ack on trigger");
		wr(ADDR_CONTROL, 8'h20);
		wr(ADDR_SHIFT, 8'hFF);
		u_sbus_master.bus_release_edge();
		u_sbus_master.cmd();
		u_sbus_master.send(8'h5A, ack);
		repeat (12) @(posedge core_clk);
		chk(8'(irqs - n), 8'h01, "matching address only");
	endtask
	task automatic t_off;
		wr(ADDR_MODE, 8'h14);
		rd(ADDR_MODE, rv);
		chk(rv, 8'h15, "compare zero when off");
		rd(ADDR_CONTROL, rv);
		chk(rv & 8'h4C, 8'h00, "flags cleared when off");
	endtask
	// ------------------------------------------------------------
	// main sequence and hang guard
	// ------------------------------------------------------------
	initial
	begin
		repeat (6) @(posedge core_clk);
		rst <= 1'b0;
		t_regs();
		t_addr();
		t_wake();
		t_off();
		give_verdict();
	end
	initial
	begin
		repeat (60000) @(posedge core_clk);
		num_errors++;
		give_verdict();
	end
endmodule // testbench
`default_nettype wire
